// [common/drive_fault_pkg.sv]
// constants and types shared by the drive fault supervisor
package drive_fault_pkg;
	// frequency in units of 0.01 Hz
	localparam int FREQ_W = 17;
	localparam logic [16:0] FREQ_LIMIT_MIN = 17'h0_0000;
	localparam logic [16:0] FREQ_LIMIT_MAX = 17'h1_869f;
	localparam logic [16:0] FREQ_LIMIT_RESET = 17'h1_869f;

	// fault codes as shown on the display
	localparam logic [15:0] CODE_NONE = 16'h0000;
	localparam logic [15:0] CODE_FREQ = 16'h1100;
	localparam logic [15:0] CODE_EXT = 16'h1454;
	localparam logic [15:0] CODE_TEMP = 16'h0400;

	// motor temperature mode values
	localparam logic [4:0] TMODE_OFF = 5'h00;
	localparam logic [4:0] TMODE_CONTACT_WARN = 5'h01;
	localparam logic [4:0] TMODE_CONTACT_TRIP = 5'h02;
	localparam logic [4:0] TMODE_CONTACT_DELAY = 5'h03;
	localparam logic [4:0] TMODE_PTC_WARN = 5'h0b;
	localparam logic [4:0] TMODE_PTC_TRIP = 5'h0c;
	localparam logic [4:0] TMODE_PTC_DELAY = 5'h0d;
	localparam logic [4:0] TMODE_RTD_WARN = 5'h15;
	localparam logic [4:0] TMODE_RTD_TRIP = 5'h16;

	// winding temperature in signed degrees celsius
	localparam int TEMP_W = 10;
	localparam logic signed [10:0] ACK_HYST_C = 11'sh005;

	// digital inputs for the thermal contact
	localparam int DIN_W = 8;
	localparam int SEL_W = 3;
	localparam logic [2:0] CONTACT_SEL_DEFAULT = 3'h0;

	// delayed trip time
	localparam int DELAY_S = 60;
	localparam int CLK_HZ = 100_000_000;
	localparam int DELAY_W = 33;
	localparam logic [32:0] DELAY_CYCLES = 33'(64'(DELAY_S) * 64'(CLK_HZ));

	typedef enum logic [1:0] {
		ext_disabled = 2'b00,
		ext_switch_off = 2'b01,
		ext_decel = 2'b10,
		ext_emergency = 2'b11
	} ext_mode_t;

	typedef enum logic [1:0] {
		cause_none = 2'b00,
		cause_freq = 2'b01,
		cause_ext = 2'b10,
		cause_temp = 2'b11
	} cause_t;

	typedef enum logic [1:0] {
		kind_off = 2'b00,
		kind_contact = 2'b01,
		kind_ptc = 2'b10,
		kind_rtd = 2'b11
	} kind_t;

	typedef enum logic [1:0] {
		act_none = 2'b00,
		act_warn = 2'b01,
		act_trip = 2'b10,
		act_delay = 2'b11
	} action_t;
endpackage

// [design/drive_fault_supervisor.sv]
// drive fault supervisor: frequency limit, external error, motor temperature
// Functional notes
// - overfrequency on stator or actual trips, code 1100
// - limit accepts 0 to 999.99 Hz, resets 999.99
// - external error source: logic signal or digital input
// - external mode 0 ignores the error
// - mode 1 switches off, code 1454
// - mode 2 ramps down normally, code 1454
// - mode 3 emergency ramp stop, code 1454
// - temperature mode 0 monitors nothing
// - modes 1, 11, 21 only warn
// - modes 2, 12, 22 trip at once, code 0400
// - modes 3, 13 trip after one minute
// - contact input chosen by selector, default first input
// - contact polarity sinking or sourcing
// - thermistor modes compare analog input with response level
// - resistive modes compare winding temperature with maximum
// - winding temperature readable as status
// - contact/thermistor fault acknowledged only after overload clears
// - resistive fault acknowledged only five degrees below threshold
`timescale 1ns/1ps
module drive_fault_supervisor #(
	parameter int ANA_W = 12,
	parameter logic [32:0] TRIP_DELAY_CYCLES = drive_fault_pkg::DELAY_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// frequency supervision
	input wire logic [16:0] stator_freq,
	input wire logic [16:0] actual_freq,
	input wire logic freq_limit_wr,
	input wire logic [16:0] freq_limit_wdata,
	// external error
	input wire logic ext_err_logic,
	input wire logic ext_err_digital,
	input wire logic ext_err_source_sel,
	input wire logic [1:0] ext_err_mode,
	// motor temperature configuration
	input wire logic [4:0] temp_mode,
	input wire logic thermal_contact_input_select_wr,
	input wire logic [2:0] thermal_contact_input_select_wdata,
	input wire logic multifunction_input_two_pnp,
	input wire logic [7:0] max_winding_temp,
	input wire logic [ANA_W-1:0] thermistor_response_level,
	// motor temperature sensors
	input wire logic [7:0] digital_inputs,
	input wire logic [ANA_W-1:0] multifunction_input_two,
	input wire logic signed [9:0] winding_temp,
	// acknowledgment
	input wire logic fault_ack,
	// drive stage and display
	output logic drive_off,
	output logic ramp_stop,
	output logic emergency_stop,
	output logic fault_active,
	output logic [15:0] fault_code,
	output logic thermal_warning,
	output logic signed [9:0] winding_temp_status,
	output logic [16:0] freq_limit,
	output logic [2:0] thermal_contact_input_select
);
	// sensor family of a temperature mode
	function automatic drive_fault_pkg::kind_t temp_kind(input logic [4:0] mode);
		unique case (mode)
			drive_fault_pkg::TMODE_CONTACT_WARN,
			drive_fault_pkg::TMODE_CONTACT_TRIP,
			drive_fault_pkg::TMODE_CONTACT_DELAY: temp_kind = drive_fault_pkg::kind_contact;
			drive_fault_pkg::TMODE_PTC_WARN,
			drive_fault_pkg::TMODE_PTC_TRIP,
			drive_fault_pkg::TMODE_PTC_DELAY: temp_kind = drive_fault_pkg::kind_ptc;
			drive_fault_pkg::TMODE_RTD_WARN,
			drive_fault_pkg::TMODE_RTD_TRIP: temp_kind = drive_fault_pkg::kind_rtd;
			default: temp_kind = drive_fault_pkg::kind_off;
		endcase
	endfunction

	// reaction of a temperature mode
	function automatic drive_fault_pkg::action_t temp_action(input logic [4:0] mode);
		unique case (mode)
			drive_fault_pkg::TMODE_CONTACT_WARN,
			drive_fault_pkg::TMODE_PTC_WARN,
			drive_fault_pkg::TMODE_RTD_WARN: temp_action = drive_fault_pkg::act_warn;
			drive_fault_pkg::TMODE_CONTACT_TRIP,
			drive_fault_pkg::TMODE_PTC_TRIP,
			drive_fault_pkg::TMODE_RTD_TRIP: temp_action = drive_fault_pkg::act_trip;
			drive_fault_pkg::TMODE_CONTACT_DELAY,
			drive_fault_pkg::TMODE_PTC_DELAY: temp_action = drive_fault_pkg::act_delay;
			default: temp_action = drive_fault_pkg::act_none;
		endcase
	endfunction

	drive_fault_pkg::cause_t cause;
	drive_fault_pkg::cause_t next_cause;
	drive_fault_pkg::ext_mode_t reaction;
	drive_fault_pkg::ext_mode_t next_reaction;
	drive_fault_pkg::ext_mode_t ext_mode;
	drive_fault_pkg::kind_t kind;
	drive_fault_pkg::action_t action;
	logic freq_over;
	logic ext_selected;
	logic ext_hit;
	logic contact_raw;
	logic contact_hot;
	logic overload;
	logic delay_run;
	logic delay_expired;
	logic temp_trip_now;
	logic ack_ok;
	logic signed [10:0] temp_wide;
	logic signed [10:0] temp_max;
	logic signed [10:0] temp_ack_level;
	logic [15:0] next_code;

	assign ext_mode = drive_fault_pkg::ext_mode_t'(ext_err_mode);
	assign kind = temp_kind(temp_mode);
	assign action = temp_action(temp_mode);
	assign temp_wide = 11'(winding_temp);
	assign temp_max = $signed({3'b000, max_winding_temp});
	assign temp_ack_level = temp_max - drive_fault_pkg::ACK_HYST_C;

	// overfrequency on either measured frequency
	assign freq_over = (stator_freq > freq_limit) || (actual_freq > freq_limit);

	// external error source and reaction enable
	assign ext_selected = ext_err_source_sel ? ext_err_digital : ext_err_logic;
	assign ext_hit = ext_selected && (ext_mode != drive_fault_pkg::ext_disabled);

	// thermal contact, polarity sinking (active low) or sourcing (active high)
	assign contact_raw = digital_inputs[thermal_contact_input_select];
	assign contact_hot = multifunction_input_two_pnp ? contact_raw : !contact_raw;

	// overload detection per sensor family
	always_comb begin
		unique case (kind)
			drive_fault_pkg::kind_contact: overload = contact_hot;
			drive_fault_pkg::kind_ptc: overload = multifunction_input_two >= thermistor_response_level;
			drive_fault_pkg::kind_rtd: overload = temp_wide >= temp_max;
			drive_fault_pkg::kind_off: overload = 1'b0;
		endcase
	end

	assign delay_run = overload && (action == drive_fault_pkg::act_delay) &&
		(cause != drive_fault_pkg::cause_temp);

	trip_delay_timer #(
		.W(drive_fault_pkg::DELAY_W),
		.CYCLES(TRIP_DELAY_CYCLES)
	) u_delay (
		.clk(clk),
		.reset_n(reset_n),
		.run(delay_run),
		.expired(delay_expired)
	);

	assign temp_trip_now = (overload && (action == drive_fault_pkg::act_trip)) ||
		(delay_expired && delay_run);

	// acknowledgment condition of the latched fault
	always_comb begin
		unique case (cause)
			drive_fault_pkg::cause_freq: ack_ok = !freq_over;
			drive_fault_pkg::cause_ext: ack_ok = !ext_selected;
			drive_fault_pkg::cause_temp: ack_ok = (kind == drive_fault_pkg::kind_rtd) ?
				(temp_wide <= temp_ack_level) : !overload;
			drive_fault_pkg::cause_none: ack_ok = 1'b1;
		endcase
	end

	// fault latch, first cause wins, held until acknowledged
	always_comb begin
		next_cause = cause;
		next_reaction = reaction;
		if (cause == drive_fault_pkg::cause_none) begin
			if (freq_over) begin
				next_cause = drive_fault_pkg::cause_freq;
			end else if (ext_hit) begin
				next_cause = drive_fault_pkg::cause_ext;
				next_reaction = ext_mode;
			end else if (temp_trip_now) begin
				next_cause = drive_fault_pkg::cause_temp;
			end
		end else if (fault_ack && ack_ok) begin
			next_cause = drive_fault_pkg::cause_none;
			next_reaction = drive_fault_pkg::ext_disabled;
		end
	end

	always_comb begin
		unique case (next_cause)
			drive_fault_pkg::cause_freq: next_code = drive_fault_pkg::CODE_FREQ;
			drive_fault_pkg::cause_ext: next_code = drive_fault_pkg::CODE_EXT;
			drive_fault_pkg::cause_temp: next_code = drive_fault_pkg::CODE_TEMP;
			drive_fault_pkg::cause_none: next_code = drive_fault_pkg::CODE_NONE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cause <= drive_fault_pkg::cause_none;
			reaction <= drive_fault_pkg::ext_disabled;
		end else begin
			cause <= next_cause;
			reaction <= next_reaction;
		end
	end

	// drive stage commands and fault display
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			drive_off <= 1'b0;
			ramp_stop <= 1'b0;
			emergency_stop <= 1'b0;
			fault_active <= 1'b0;
			fault_code <= drive_fault_pkg::CODE_NONE;
		end else begin
			drive_off <= (next_cause == drive_fault_pkg::cause_freq) ||
				(next_cause == drive_fault_pkg::cause_temp) ||
				(next_reaction == drive_fault_pkg::ext_switch_off);
			ramp_stop <= next_reaction == drive_fault_pkg::ext_decel;
			emergency_stop <= next_reaction == drive_fault_pkg::ext_emergency;
			fault_active <= next_cause != drive_fault_pkg::cause_none;
			fault_code <= next_code;
		end
	end

	// warning-only temperature modes
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			thermal_warning <= 1'b0;
		end else begin
			thermal_warning <= overload && (action == drive_fault_pkg::act_warn);
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			winding_temp_status <= '0;
		end else begin
			winding_temp_status <= winding_temp;
		end
	end

	// settings, out-of-range limit writes are ignored
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			freq_limit <= drive_fault_pkg::FREQ_LIMIT_RESET;
		end else if (freq_limit_wr && freq_limit_wdata <= drive_fault_pkg::FREQ_LIMIT_MAX) begin
			freq_limit <= freq_limit_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			thermal_contact_input_select <= drive_fault_pkg::CONTACT_SEL_DEFAULT;
		end else if (thermal_contact_input_select_wr) begin
			thermal_contact_input_select <= thermal_contact_input_select_wdata;
		end
	end

	a_freq_trip: assert property (@(posedge clk) disable iff (!reset_n)
		(cause == drive_fault_pkg::cause_none) && freq_over |=>
		drive_off && fault_code == drive_fault_pkg::CODE_FREQ) else $error("no freq trip");
	a_limit_range: assert property (@(posedge clk) disable iff (!reset_n)
		freq_limit <= drive_fault_pkg::FREQ_LIMIT_MAX) else $error("limit out of range");
	a_ext_ignored: assert property (@(posedge clk) disable iff (!reset_n)
		(cause == drive_fault_pkg::cause_none) && ext_mode == drive_fault_pkg::ext_disabled &&
		!freq_over && !temp_trip_now |=> !fault_active) else $error("ext not ignored");
	a_ext_switch: assert property (@(posedge clk) disable iff (!reset_n)
		(cause == drive_fault_pkg::cause_none) && !freq_over && ext_selected &&
		ext_mode == drive_fault_pkg::ext_switch_off |=> drive_off && !ramp_stop &&
		fault_code == drive_fault_pkg::CODE_EXT) else $error("ext switch off wrong");
	a_ext_decel: assert property (@(posedge clk) disable iff (!reset_n)
		(cause == drive_fault_pkg::cause_none) && !freq_over && ext_selected &&
		ext_mode == drive_fault_pkg::ext_decel |=> ramp_stop && !drive_off &&
		fault_code == drive_fault_pkg::CODE_EXT) else $error("ext decel wrong");
	a_ext_emerg: assert property (@(posedge clk) disable iff (!reset_n)
		(cause == drive_fault_pkg::cause_none) && !freq_over && ext_selected &&
		ext_mode == drive_fault_pkg::ext_emergency |=> emergency_stop &&
		fault_code == drive_fault_pkg::CODE_EXT) else $error("ext emergency wrong");
	a_temp_off: assert property (@(posedge clk) disable iff (!reset_n)
		kind == drive_fault_pkg::kind_off |=> !thermal_warning) else $error("warning when off");
	a_warn_runs: assert property (@(posedge clk) disable iff (!reset_n)
		(cause == drive_fault_pkg::cause_none) && !freq_over && !ext_hit && overload &&
		action == drive_fault_pkg::act_warn |=> thermal_warning && !drive_off)
		else $error("warning mode tripped");
	a_temp_trip: assert property (@(posedge clk) disable iff (!reset_n)
		(cause == drive_fault_pkg::cause_none) && !freq_over && !ext_hit && overload &&
		action == drive_fault_pkg::act_trip |=> drive_off &&
		fault_code == drive_fault_pkg::CODE_TEMP) else $error("no thermal trip");
	a_rtd_ack: assert property (@(posedge clk) disable iff (!reset_n)
		(cause == drive_fault_pkg::cause_temp) && kind == drive_fault_pkg::kind_rtd &&
		temp_wide > temp_ack_level |=> fault_code == drive_fault_pkg::CODE_TEMP)
		else $error("early thermal ack");
	a_fault_hold: assert property (@(posedge clk) disable iff (!reset_n)
		fault_active && !fault_ack |=> $stable(fault_code) && fault_active)
		else $error("fault dropped without ack");
endmodule

// [design/trip_delay_timer.sv]
// delay timer for the delayed thermal trip
`timescale 1ns/1ps
module trip_delay_timer #(
	parameter int W = drive_fault_pkg::DELAY_W,
	parameter logic [32:0] CYCLES = drive_fault_pkg::DELAY_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// control and result
	input wire logic run,
	output logic expired
);
	logic [W-1:0] count;
	logic [W-1:0] next_count;
	localparam logic [W-1:0] LAST = W'(CYCLES - 33'h0_0001);

	// counts only while run holds, restarts from zero when it drops
	always_comb begin
		if (!run) begin
			next_count = '0;
		end else if (count == LAST) begin
			next_count = count;
		end else begin
			next_count = count + W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			expired <= 1'b0;
		end else begin
			expired <= run && (count == LAST);
		end
	end

	a_restart_clear: assert property (@(posedge clk) disable iff (!reset_n)
		!run |=> count == '0) else $error("timer did not restart");
	a_expire_needs_run: assert property (@(posedge clk) disable iff (!reset_n)
		expired |-> $past(run) && $past(count) == LAST) else $error("early expiry");
endmodule

// [tb/plant_sensor_model.sv]
// behavioural model of the motor temperature sensor and the plant fault source
`timescale 1ns/1ps
module plant_sensor_model (
	// clock
	input wire logic clk,
	// scenario control
	input wire logic hot,
	input wire logic signed [9:0] temp_c,
	input wire logic pnp,
	input wire logic [2:0] contact_idx,
	input wire logic ext_fault,
	input wire logic ext_sel,
	// sensor and fault lines
	output logic [7:0] digital_inputs,
	output logic [11:0] multifunction_input_two,
	output logic signed [9:0] winding_temp,
	output logic ext_err_logic,
	output logic ext_err_digital
);
	logic tog = 1'b0;
	always @(negedge clk) begin
		tog <= ~tog;
	end
	// unselected lines carry a changing pattern, never the last value
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			digital_inputs[i] = tog ^ i[0];
		end
		digital_inputs[contact_idx] = pnp ? hot : ~hot;
	end
	assign multifunction_input_two = hot ? 12'hc00 : 12'h100;
	assign winding_temp = temp_c;
	assign ext_err_logic = ext_sel ? tog : ext_fault;
	assign ext_err_digital = ext_sel ? ext_fault : ~tog;
endmodule

// [tb/testbench.sv]
// self-checking bench for the drive fault supervisor
`timescale 1ns/1ps
module testbench;
	localparam logic [32:0] D = 33'h0_0000_0014;
	logic clk = 1'b0, reset_n = 1'b0, freq_limit_wr = 1'b0, ext_err_source_sel = 1'b0;
	logic thermal_contact_input_select_wr = 1'b0, multifunction_input_two_pnp = 1'b0;
	logic fault_ack = 1'b0, hot = 1'b0, ext_fault = 1'b0;
	logic [16:0] stator_freq = '0, actual_freq = '0, freq_limit_wdata = '0;
	logic [1:0] ext_err_mode = '0;
	logic [4:0] temp_mode = '0;
	logic [2:0] thermal_contact_input_select_wdata = '0, contact_idx = '0;
	logic [7:0] max_winding_temp = 8'h96;
	logic [11:0] response_level = 12'h800;
	logic signed [9:0] temp_c = 10'sh014;
	logic drive_off, ramp_stop, emergency_stop, fault_active, thermal_warning;
	logic ext_err_logic, ext_err_digital;
	logic [15:0] fault_code;
	logic signed [9:0] winding_temp_status, winding_temp;
	logic [16:0] freq_limit;
	logic [2:0] thermal_contact_input_select;
	logic [7:0] digital_inputs;
	logic [11:0] multifunction_input_two;
	int err_total = 0, cmp_count = 0;

	always #5 clk = ~clk;

	plant_sensor_model partner (.clk, .hot, .temp_c, .pnp(multifunction_input_two_pnp),
		.contact_idx, .ext_fault, .ext_sel(ext_err_source_sel), .digital_inputs,
		.multifunction_input_two, .winding_temp, .ext_err_logic, .ext_err_digital);

	drive_fault_supervisor #(.ANA_W(12), .TRIP_DELAY_CYCLES(D)) dut (.clk, .reset_n,
		.stator_freq, .actual_freq, .freq_limit_wr, .freq_limit_wdata, .ext_err_logic,
		.ext_err_digital, .ext_err_source_sel, .ext_err_mode, .temp_mode,
		.thermal_contact_input_select_wr, .thermal_contact_input_select_wdata,
		.multifunction_input_two_pnp, .max_winding_temp,
		.thermistor_response_level(response_level), .digital_inputs, .multifunction_input_two,
		.winding_temp, .fault_ack, .drive_off, .ramp_stop, .emergency_stop, .fault_active,
		.fault_code, .thermal_warning, .winding_temp_status, .freq_limit,
		.thermal_contact_input_select);

	task automatic chk_word(input logic [16:0] got, input logic [16:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		$display("compares %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic ack;
		fault_ack = 1'b1;
		cyc(1);
		fault_ack = 1'b0;
		cyc(1);
	endtask
	task automatic trip_chk(input logic [15:0] code, input logic off, rs, es);
		chk_bit(fault_active, 1'b1);
		chk_word({1'b0, fault_code}, {1'b0, code});
		chk_bit(drive_off, off);
		chk_bit(ramp_stop, rs);
		chk_bit(emergency_stop, es);
	endtask
	task automatic clear_chk;
		chk_bit(fault_active, 1'b0);
		chk_word({1'b0, fault_code}, 17'h0_0000);
		chk_bit(drive_off, 1'b0);
	endtask
	task automatic write_limit(input logic [16:0] v);
		freq_limit_wr = 1'b1;
		freq_limit_wdata = v;
		cyc(1);
		freq_limit_wr = 1'b0;
		cyc(1);
	endtask

	task automatic t_reset;
		chk_word(freq_limit, drive_fault_pkg::FREQ_LIMIT_RESET);
		chk_word({14'h0000, thermal_contact_input_select}, 17'h0_0000);
		clear_chk();
		$display("test reset done");
	endtask
	task automatic t_freq;
		write_limit(17'h0_03e8);
		chk_word(freq_limit, 17'h0_03e8);
		write_limit(17'h1_86a0);
		chk_word(freq_limit, 17'h0_03e8);
		for (int s = 0; s < 2; s++) begin
			stator_freq = 17'h0_03e8;
			actual_freq = 17'h0_03e8;
			cyc(2);
			chk_bit(fault_active, 1'b0);
			if (s == 0) stator_freq = 17'h0_03e9;
			else actual_freq = 17'h0_03e9;
			cyc(1);
			trip_chk(drive_fault_pkg::CODE_FREQ, 1'b1, 1'b0, 1'b0);
			ack();
			chk_bit(fault_active, 1'b1);
			stator_freq = 17'h0_0000;
			actual_freq = 17'h0_0000;
			cyc(2);
			trip_chk(drive_fault_pkg::CODE_FREQ, 1'b1, 1'b0, 1'b0);
			ack();
			clear_chk();
		end
		write_limit(17'h1_869f);
		chk_word(freq_limit, 17'h1_869f);
		$display("test frequency done");
	endtask
	task automatic t_ext;
		for (int m = 0; m < 4; m++) begin
			for (int src = 0; src < 2; src++) begin
				ext_err_source_sel = src[0];
				ext_err_mode = m[1:0];
				ext_fault = 1'b1;
				cyc(2);
				if (m == 0) chk_bit(fault_active, 1'b0);
				else trip_chk(drive_fault_pkg::CODE_EXT, m == 1, m == 2, m == 3);
				ext_fault = 1'b0;
				cyc(1);
				ack();
				clear_chk();
			end
		end
		ext_err_mode = 2'b00;
		$display("test external done");
	endtask
	task automatic trip_cycle(input logic [4:0] mode);
		temp_mode = mode;
		hot = 1'b1;
		cyc(2);
		trip_chk(drive_fault_pkg::CODE_TEMP, 1'b1, 1'b0, 1'b0);
		ack();
		chk_bit(fault_active, 1'b1);
		hot = 1'b0;
		cyc(1);
		ack();
		clear_chk();
		temp_mode = drive_fault_pkg::TMODE_OFF;
	endtask
	task automatic t_temp;
		logic [4:0] modes [4];
		modes = '{drive_fault_pkg::TMODE_OFF, drive_fault_pkg::TMODE_CONTACT_WARN,
			drive_fault_pkg::TMODE_PTC_WARN, drive_fault_pkg::TMODE_RTD_WARN};
		multifunction_input_two_pnp = 1'b0;
		trip_cycle(drive_fault_pkg::TMODE_CONTACT_TRIP);
		multifunction_input_two_pnp = 1'b1;
		trip_cycle(drive_fault_pkg::TMODE_CONTACT_TRIP);
		response_level = 12'hc00;
		trip_cycle(drive_fault_pkg::TMODE_PTC_TRIP);
		response_level = 12'hc01;
		temp_mode = drive_fault_pkg::TMODE_PTC_TRIP;
		hot = 1'b1;
		cyc(2);
		chk_bit(fault_active, 1'b0);
		hot = 1'b0;
		temp_mode = drive_fault_pkg::TMODE_OFF;
		response_level = 12'h800;
		thermal_contact_input_select_wr = 1'b1;
		thermal_contact_input_select_wdata = 3'h5;
		contact_idx = 3'h5;
		cyc(1);
		thermal_contact_input_select_wr = 1'b0;
		cyc(1);
		chk_word({14'h0000, thermal_contact_input_select}, 17'h0_0005);
		trip_cycle(drive_fault_pkg::TMODE_CONTACT_TRIP);
		for (int i = 0; i < 4; i++) begin
			temp_mode = modes[i];
			hot = 1'b1;
			temp_c = 10'sh0a0;
			cyc(3);
			chk_bit(thermal_warning, i != 0);
			chk_bit(fault_active, 1'b0);
			hot = 1'b0;
			temp_c = 10'sh014;
			cyc(2);
			chk_bit(thermal_warning, 1'b0);
		end
		$display("test temperature done");
	endtask
	task automatic t_rtd;
		temp_mode = drive_fault_pkg::TMODE_RTD_TRIP;
		temp_c = 10'sh095;
		cyc(2);
		chk_bit(fault_active, 1'b0);
		chk_word(17'(winding_temp_status), 17'h0_0095);
		temp_c = 10'sh096;
		cyc(2);
		trip_chk(drive_fault_pkg::CODE_TEMP, 1'b1, 1'b0, 1'b0);
		temp_c = 10'sh092;
		cyc(1);
		ack();
		chk_bit(fault_active, 1'b1);
		temp_c = 10'sh091;
		cyc(1);
		ack();
		clear_chk();
		temp_mode = drive_fault_pkg::TMODE_OFF;
		$display("test resistive done");
	endtask
	task automatic t_delay;
		int n;
		for (int k = 0; k < 2; k++) begin
			temp_mode = k ? drive_fault_pkg::TMODE_PTC_DELAY : drive_fault_pkg::TMODE_CONTACT_DELAY;
			hot = 1'b1;
			cyc(18);
			hot = 1'b0;
			cyc(1);
			chk_bit(fault_active, 1'b0);
			hot = 1'b1;
			n = 0;
			while (fault_active !== 1'b1) begin
				cyc(1);
				n++;
				if (n > 60) begin
					err_total++;
					stop_test();
				end
			end
			chk_bit(n >= 20 && n <= 22, 1'b1);
			chk_word({1'b0, fault_code}, {1'b0, drive_fault_pkg::CODE_TEMP});
			hot = 1'b0;
			cyc(1);
			ack();
			clear_chk();
		end
		temp_mode = drive_fault_pkg::TMODE_OFF;
		$display("test delayed done");
	endtask

	initial begin
		repeat (2) @(posedge clk);
		@(negedge clk);
		reset_n = 1'b1;
		t_reset();
		t_freq();
		t_ext();
		t_temp();
		t_rtd();
		t_delay();
		stop_test();
	end
endmodule
